// [include/ces_pkg.sv]
// Purpose: Shared constants and carriers for the exception sequencer.
// Assumes: One bus clock, synchronous active-high reset.
// Notes: Summary of operation is listed below.
//
// Summary of operation
// - Finish current instruction before interrupt entry.
// - Vector from highest pending interrupt at start.
// - Stack return low, high, index low, accumulator, flags.
// - Set global mask after flags stacked.
// - Fetch vector high byte then low byte.
// - One idle bus cycle after vector fetch.
// - Fetch three program bytes to fill queue.
// - Index high byte is never stacked.
// - Service routine may clear mask for nesting.
// - Soft trap same entry, never masked.
// - Wait clears mask, then stops core clocks.
// - Interrupt or reset wakes wait, normal handling.
// - Debug halt command in wait enters debug.
// - Optional minimal clocks kept running in stop.
// - Debug enabled and attached keeps oscillator in stop.
// - Debug halt command in stop enters debug.
// - Debug halt opcode enters active background mode.
// - Leave debug only by resume, step, tagged resume.
package ces_pkg;

    // Number of interrupt sources; index 0 is highest priority.
    localparam int NUM_IRQ = 8;
    // Vector table top; source n uses VEC_TOP - 2*(n+2).
    localparam logic [15:0] VEC_TOP = 16'hFFFE;
    // Soft trap vector slot.
    localparam logic [15:0] TRAP_VEC = 16'hFFFC;
    // Position of the global mask bit within the flags register.
    localparam int MASK_POS = 3;
    // Number of program bytes fetched to refill the queue.
    localparam logic [1:0] QUEUE_FILL = 2'h3;

    // Serial debug commands decoded by the debug interface.
    typedef enum logic [2:0] {
        CES_CMD_NONE = 3'b000,
        CES_CMD_HALT = 3'b001,
        CES_CMD_RESUME = 3'b010,
        CES_CMD_STEP = 3'b011,
        CES_CMD_TAGGED = 3'b100
    } ces_cmd_e;

    // Register context handed in by the datapath.
    typedef struct packed {
        logic [15:0] ret_ptr;
        logic [7:0] index_low;
        logic [7:0] accum;
        logic [7:0] cond_code_reg;
    } ces_ctx_s;

    // One bus cycle request driven by the sequencer.
    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [7:0] wdata;
    } ces_bus_s;

endpackage : ces_pkg

// [hw/ces_sequencer.sv]
// Purpose: Exception entry, low-power and debug-mode sequencer of the core.
// Assumes: Datapath raises instruction boundary and decoded opcode pulses.
// Notes: Bus cycles complete in one clock; debug pin inputs are synchronised.
//        A serial command acts once, on its first synchronised cycle.
`timescale 1ns/10ps
`default_nettype none

module ces_sequencer (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic srst,
    // Datapath handshake.
    input wire logic insn_boundary,
    input wire logic soft_trap_opcode,
    input wire logic wait_opcode,
    input wire logic stop_opcode,
    input wire logic debug_halt_opcode,
    input wire logic mask_clear_req,
    input wire ces_pkg::ces_ctx_s ctx,
    input wire logic [15:0] stack_ptr,
    input wire logic [7:0] bus_rdata,
    // Interrupt sources, asynchronous levels.
    // Bit zero has the highest priority.
    input wire logic [ces_pkg::NUM_IRQ-1:0] irq_req,
    // Debug interface, from the debug wire logic on another clock.
    input wire logic [2:0] debug_cmd,
    input wire logic debug_enable_bit,
    input wire logic debug_wire_pin,
    // Configuration strap for keeping minimal clocks in stop.
    input wire logic stop_clk_keep,
    // Bus and status outputs.
    // Every output below comes straight from a register.
    output ces_pkg::ces_bus_s bus,
    output logic [15:0] new_pc,
    output logic pc_load,
    output logic global_mask,
    output logic core_clk_en,
    output logic osc_keep,
    output logic periodic_keep,
    output logic in_background,
    output logic busy
);
    import ces_pkg::*;

    // --------------------------------------------------------------
    // Sequencer states
    // --------------------------------------------------------------
    typedef enum logic [3:0] {
        CES_RUN = 4'b0000,
        CES_PUSH = 4'b0001,
        CES_VEC_HI = 4'b0010,
        CES_VEC_LO = 4'b0011,
        CES_IDLE_CYC = 4'b0100,
        CES_FILL = 4'b0101,
        CES_WAIT = 4'b0110,
        CES_STOP = 4'b0111,
        CES_DEBUG_HALT_OPCODE = 4'b1000
    } ces_state_e;

    // Working registers of the sequencer.
    ces_state_e state; // Current state.
    logic [2:0] push_idx; // Which context byte is being stacked.
    logic [1:0] fill_cnt; // Queue bytes still to fetch.
    logic [15:0] sp; // Working stack pointer.
    logic [15:0] vec_addr; // Latched vector slot address.
    logic [15:0] vec_val; // Assembled vector value.
    logic [7:0] flags_img; // Flags image to stack.

    // --------------------------------------------------------------
    // Input synchronisers
    // --------------------------------------------------------------
    logic [NUM_IRQ-1:0] irq_s1; // First stage, read only by second.
    logic [NUM_IRQ-1:0] irq_sync; // Synchronised requests.
    logic [2:0] cmd_s1; // First stage of the command.
    logic [2:0] cmd_sync; // Synchronised command.
    logic [1:0] dbg_s1; // First stage of enable and pin.
    logic [1:0] dbg_sync; // Synchronised enable and pin.
    logic [2:0] cmd_prev; // Command seen on the previous cycle.

    // The host holds each serial command for several cycles, and the
    // synchroniser delays it by two cycles. Acting on the level alone would
    // let a resume that is still standing throw the core straight back out
    // of a halt opcode that follows it, so only a change of command counts.

    // Two flip-flops on every asynchronous input.
    // No reset is needed here: the stages flush within two cycles of reset.
    always_ff @(posedge sys_clk) begin
        irq_s1 <= irq_req;
        irq_sync <= irq_s1;
        cmd_s1 <= debug_cmd;
        cmd_sync <= cmd_s1;
        dbg_s1 <= {debug_enable_bit, debug_wire_pin};
        dbg_sync <= dbg_s1;
    end

    // --------------------------------------------------------------
    // Decoding
    // --------------------------------------------------------------
    // Slot address for the highest-priority pending source.
    // The loop runs from the lowest priority up, so the last hit wins.
    function automatic logic [15:0] pick_vec(input logic [NUM_IRQ-1:0] req);
        logic [15:0] a;
        a = VEC_TOP;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (req[i]) begin
                a = VEC_TOP - 16'((i + 2) * 2);
            end
        end
        return a;
    endfunction : pick_vec

    wire irq_any = |irq_sync; // Some source is pending.
    wire irq_take = irq_any && !global_mask; // Masked requests wait.
    wire cmd_fresh = cmd_sync != cmd_prev; // A new command has just arrived.
    wire cmd_halt = cmd_fresh && (cmd_sync == CES_CMD_HALT); // Debug halt command.
    wire cmd_go = cmd_fresh && ((cmd_sync == CES_CMD_RESUME) || (cmd_sync == CES_CMD_STEP) ||
        (cmd_sync == CES_CMD_TAGGED)); // Any resume-type command.
    wire dbg_attached = dbg_sync[1] && dbg_sync[0]; // Enabled and host present.
    wire at_bound = insn_boundary && (state == CES_RUN); // Instruction done.
    wire start_trap = at_bound && soft_trap_opcode; // Trap ignores mask.
    wire start_irq = at_bound && !soft_trap_opcode && irq_take;
    wire [15:0] irq_vec = pick_vec(irq_sync);
    wire [15:0] sp_dec = sp - 16'h0001; // Stack grows downward.

    // Context byte selected for the current push; index high never stacked.
    // The handler must save the index high byte itself if it changes it.
    logic [7:0] push_byte;
    always_comb begin
        case (push_idx)
            3'h0: push_byte = ctx.ret_ptr[7:0];
            3'h1: push_byte = ctx.ret_ptr[15:8];
            3'h2: push_byte = ctx.index_low;
            3'h3: push_byte = ctx.accum;
            default: push_byte = flags_img;
        endcase
    end

    // --------------------------------------------------------------
    // Sequencer
    // --------------------------------------------------------------
    // Main state machine; all outputs are registers.
    // Entry runs eleven cycles from the accepted boundary: five stack
    // writes, two vector reads, one free cycle and three queue fetches.
    // The wait, stop and background states hold the core until an
    // outside event, so they never count cycles of their own.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= CES_RUN;
            push_idx <= 3'h0;
            fill_cnt <= 2'h0;
            sp <= 16'h0000;
            vec_addr <= 16'h0000;
            vec_val <= 16'h0000;
            flags_img <= 8'h00;
            bus <= '0;
            new_pc <= 16'h0000;
            pc_load <= 1'b0;
            global_mask <= 1'b1;
            core_clk_en <= 1'b1;
            osc_keep <= 1'b0;
            periodic_keep <= 1'b0;
            in_background <= 1'b0;
            busy <= 1'b0;
            cmd_prev <= CES_CMD_NONE; // Idle line, so no false command after reset.
        end else begin
            // Bus strobe and load pulse last one cycle unless a state renews them.
            bus <= '0;
            pc_load <= 1'b0;
            // Remember the command so that a held one is acted on once.
            cmd_prev <= cmd_sync;
            case (state)
                // Normal execution; requests are looked at only on a boundary.
                CES_RUN: begin
                    // Software may clear the mask inside a handler.
                    if (mask_clear_req) begin
                        global_mask <= 1'b0;
                    end
                    if (start_trap || start_irq) begin
                        // Vector latched when the entry begins.
                        // The flags image and stack pointer are captured on the same edge; the other context bytes are read live while pushing.
                        vec_addr <= start_trap ? TRAP_VEC : irq_vec;
                        flags_img <= ctx.cond_code_reg;
                        sp <= stack_ptr;
                        push_idx <= 3'h0;
                        busy <= 1'b1;
                        state <= CES_PUSH;
                    end else if (at_bound && debug_halt_opcode) begin
                        // Breakpoint opcode parks the core for the host.
                        in_background <= 1'b1;
                        busy <= 1'b1;
                        state <= CES_DEBUG_HALT_OPCODE;
                    end else if (at_bound && wait_opcode) begin
                        // Wait opens the mask so any source can wake it.
                        global_mask <= 1'b0;
                        core_clk_en <= 1'b0;
                        state <= CES_WAIT;
                    end else if (at_bound && stop_opcode) begin
                        // Stop gates the core; the keep flags choose what stays alive.
                        core_clk_en <= 1'b0;
                        osc_keep <= dbg_attached;
                        periodic_keep <= stop_clk_keep;
                        state <= CES_STOP;
                    end
                end
                CES_PUSH: begin
                    // Stack the five context bytes in order.
                    // The stack pointer is post-decremented after every write.
                    bus <= '{valid: 1'b1, write: 1'b1, addr: sp, wdata: push_byte};
                    sp <= sp_dec;
                    push_idx <= push_idx + 3'h1;
                    // The fifth byte is the flags image; the mask rises with it,
                    // so the stacked flags still show the mask as it was.
                    if (push_idx == 3'h4) begin
                        global_mask <= 1'b1;
                        state <= CES_VEC_HI;
                    end
                end
                CES_VEC_HI: begin
                    // High vector byte first.
                    bus <= '{valid: 1'b1, write: 1'b0, addr: vec_addr, wdata: 8'h00};
                    state <= CES_VEC_LO;
                end
                CES_VEC_LO: begin
                    // Capture high byte, then read low byte.
                    // Read data stands in the cycle of its request and is taken
                    // on the edge that ends that cycle.
                    vec_val[15:8] <= bus_rdata;
                    bus <= '{valid: 1'b1, write: 1'b0, addr: vec_addr + 16'h0001,
                        wdata: 8'h00};
                    state <= CES_IDLE_CYC;
                end
                CES_IDLE_CYC: begin
                    // One free bus cycle with no access.
                    // The low vector byte arrives now and the queue count is loaded.
                    vec_val[7:0] <= bus_rdata;
                    fill_cnt <= QUEUE_FILL;
                    state <= CES_FILL;
                end
                CES_FILL: begin
                    // Three program fetches from the vector.
                    // The offset runs 0, 1, 2 as the count falls from three.
                    // The last fetch hands the vector to the program counter.
                    bus <= '{valid: 1'b1, write: 1'b0,
                        addr: vec_val + 16'(QUEUE_FILL - fill_cnt), wdata: 8'h00};
                    fill_cnt <= fill_cnt - 2'h1;
                    if (fill_cnt == 2'h1) begin
                        new_pc <= vec_val;
                        pc_load <= 1'b1;
                        busy <= 1'b0;
                        state <= CES_RUN;
                    end
                end
                // Core clocks are off; only the host or a source wakes it.
                CES_WAIT: begin
                    // The host wins over a source that arrives together with it.
                    if (cmd_halt) begin
                        core_clk_en <= 1'b1;
                        in_background <= 1'b1;
                        busy <= 1'b1;
                        state <= CES_DEBUG_HALT_OPCODE;
                    end else if (irq_any) begin
                        // Wake and take the interrupt normally.
                        core_clk_en <= 1'b1;
                        state <= CES_RUN;
                    end
                end
                // Stop: without a kept oscillator the host cannot reach the core.
                CES_STOP: begin
                    // Host halt is honoured only while the oscillator was kept.
                    if (cmd_halt && osc_keep) begin
                        core_clk_en <= 1'b1;
                        osc_keep <= 1'b0;
                        periodic_keep <= 1'b0;
                        in_background <= 1'b1;
                        busy <= 1'b1;
                        state <= CES_DEBUG_HALT_OPCODE;
                    end else if (irq_any) begin
                        // Wake from stop by interrupt, incl. periodic one.
                        core_clk_en <= 1'b1;
                        osc_keep <= 1'b0;
                        periodic_keep <= 1'b0;
                        state <= CES_RUN;
                    end
                end
                // Parked for the host; boundaries and sources are ignored here.
                CES_DEBUG_HALT_OPCODE: begin
                    // Only resume-type commands leave background.
                    if (cmd_go) begin
                        in_background <= 1'b0;
                        busy <= 1'b0;
                        state <= CES_RUN;
                    end
                end
                default: begin
                    // Unused codes fall back to normal execution.
                    state <= CES_RUN;
                end
            endcase
        end
    end

endmodule : ces_sequencer

`default_nettype wire

// [test/ces_far_end.sv]
// Purpose: Far-end model of the interrupt sources and the serial debug host.
// Assumes: The bench asks for levels and commands one cycle at a time.
// Notes: Commands are held four cycles so the two-flop synchroniser sees them.
`timescale 1ns/10ps
`default_nettype none

module ces_far_end (
    // Clock.
    input wire logic sys_clk,
    // Requests from the bench.
    input wire logic [7:0] raise,
    input wire logic [7:0] drop,
    input wire logic [2:0] send,
    // Lines into the sequencer.
    output var logic [7:0] irq_req,
    output var logic [2:0] debug_cmd
);
    logic [2:0] hold_cnt; // Cycles left on the current command.

    // Sources stay pending until the bench drops them after service.
    always @(posedge sys_clk) irq_req <= (irq_req | raise) & ~drop;

    // The host sends one command, holds it, then returns the line to idle.
    always @(posedge sys_clk) begin
        if (send != 3'h0) begin
            debug_cmd <= send;
            hold_cnt <= 3'h4;
        end else if (hold_cnt > 3'h1) begin
            hold_cnt <= hold_cnt - 3'h1;
        end else begin
            debug_cmd <= 3'h0;
            hold_cnt <= 3'h0;
        end
    end

    // Both lines start idle.
    initial begin
        irq_req = 8'h00;
        debug_cmd = 3'h0;
        hold_cnt = 3'h0;
    end
endmodule : ces_far_end
`default_nettype wire

// [test/ces_sequencer_properties.sv]
// Purpose: Timing checks on the exception sequencer ports.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to every sequencer instance.
`timescale 1ns/10ps
`default_nettype none

module ces_sequencer_properties (
    // Clock, reset and inputs.
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [7:0] bus_rdata,
    input wire logic [2:0] debug_cmd,
    input wire logic debug_enable_bit,
    input wire logic wait_opcode,
    // Outputs watched.
    input wire ces_pkg::ces_bus_s bus,
    input wire logic [15:0] new_pc,
    input wire logic pc_load,
    input wire logic global_mask,
    input wire logic core_clk_en,
    input wire logic osc_keep,
    input wire logic in_background
);
    import ces_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    // Five back-to-back stack writes make up one push.
    sequence s_push5;
        (bus.valid && bus.write) [*5];
    endsequence

    property p_push_step;
        bus.valid && bus.write && $past(bus.valid && bus.write)
            |-> bus.addr == $past(bus.addr) - 16'h0001;
    endproperty
    a_push_step: assert property (p_push_step) else $error("push address step");
    property p_mask_set;
        s_push5 |=> global_mask;
    endproperty
    a_mask_set: assert property (p_mask_set) else $error("mask not set");
    property p_vec_fetch;
        s_push5 |=> (bus.valid && !bus.write)
            ##1 (bus.valid && !bus.write && bus.addr == $past(bus.addr) + 16'h0001);
    endproperty
    a_vec_fetch: assert property (p_vec_fetch) else $error("vector fetch");
    property p_idle;
        s_push5 |=> ##2 !bus.valid;
    endproperty
    a_idle: assert property (p_idle) else $error("no idle cycle");
    property p_fill;
        pc_load |-> bus.valid && !bus.write && bus.addr == new_pc + 16'h0002
            && $past(bus.addr, 2) == new_pc;
    endproperty
    a_fill: assert property (p_fill) else $error("queue fill");
    property p_vec_pair;
        pc_load |-> new_pc == {$past(bus_rdata, 5), $past(bus_rdata, 4)};
    endproperty
    a_vec_pair: assert property (p_vec_pair) else $error("vector pairing");
    property p_wait_mask;
        $fell(core_clk_en) && $past(wait_opcode) |-> !global_mask;
    endproperty
    a_wait_mask: assert property (p_wait_mask) else $error("wait kept mask");
    property p_osc_off;
        (!debug_enable_bit) [*4] |-> !osc_keep;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("oscillator kept");
    property p_bg_hold;
        ((debug_cmd == 3'h0 || debug_cmd == 3'h1) [*4]) ##0 in_background |=> in_background;
    endproperty
    a_bg_hold: assert property (p_bg_hold) else $error("left background");

    // Main scenarios reached.
    c_entry: cover property (pc_load);
    c_wait: cover property ($fell(core_clk_en));
    c_debug: cover property ($rose(in_background));
endmodule : ces_sequencer_properties

bind ces_sequencer ces_sequencer_properties chk (.sys_clk(sys_clk), .srst(srst),
    .bus_rdata(bus_rdata), .debug_cmd(debug_cmd), .debug_enable_bit(debug_enable_bit),
    .wait_opcode(wait_opcode),
    .bus(bus), .new_pc(new_pc), .pc_load(pc_load), .global_mask(global_mask),
    .core_clk_en(core_clk_en), .osc_keep(osc_keep), .in_background(in_background));
`default_nettype wire

// [test/tb_top.sv]
// Purpose: Self-checking bench for the exception sequencer.
// Assumes: Bus cycles and latencies as the sequencer hand-over gives them.
// Notes: Context, stack pointer and pending sources are random, seed fixed.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end

module tb_top;
    import ces_pkg::*;
    logic sys_clk = 1'b0, srst = 1'b1, insn_boundary = 1'b0, soft_trap_opcode = 1'b0;
    logic wait_opcode = 1'b0, stop_opcode = 1'b0, debug_halt_opcode = 1'b0;
    logic mask_clear_req = 1'b0, debug_enable_bit = 1'b0, debug_wire_pin = 1'b0;
    logic stop_clk_keep = 1'b0, pc_load, global_mask, core_clk_en, osc_keep;
    logic periodic_keep, in_background, busy;
    ces_ctx_s ctx = '0;
    ces_bus_s bus;
    logic [15:0] stack_ptr = 16'h0000, new_pc;
    logic [7:0] bus_rdata = 8'h00, irq_req, raise = 8'h00, drop = 8'h00, pend;
    logic [2:0] debug_cmd, send = 3'h0;
    ces_cmd_e exits [3] = '{CES_CMD_RESUME, CES_CMD_STEP, CES_CMD_TAGGED};
    int fail_count = 0, n_compared = 0, seed = 30759, sel;

    always #2 sys_clk = ~sys_clk;
    // Memory answers every cycle with a new byte.
    always @(posedge sys_clk) bus_rdata <= bus_rdata * 8'h05 + 8'h3B;

    ces_sequencer dut (.sys_clk(sys_clk), .srst(srst), .insn_boundary(insn_boundary),
        .soft_trap_opcode(soft_trap_opcode), .wait_opcode(wait_opcode),
        .stop_opcode(stop_opcode), .debug_halt_opcode(debug_halt_opcode),
        .mask_clear_req(mask_clear_req), .ctx(ctx), .stack_ptr(stack_ptr),
        .bus_rdata(bus_rdata), .irq_req(irq_req), .debug_cmd(debug_cmd),
        .debug_enable_bit(debug_enable_bit), .debug_wire_pin(debug_wire_pin),
        .stop_clk_keep(stop_clk_keep), .bus(bus), .new_pc(new_pc), .pc_load(pc_load),
        .global_mask(global_mask), .core_clk_en(core_clk_en), .osc_keep(osc_keep),
        .periodic_keep(periodic_keep), .in_background(in_background), .busy(busy));
    ces_far_end far (.sys_clk(sys_clk), .raise(raise), .drop(drop), .send(send),
        .irq_req(irq_req), .debug_cmd(debug_cmd));

    task tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick
    task stop_test();
        if (fail_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : stop_test
    function automatic int pick(input logic [7:0] p);
        for (int i = 0; i < 8; i++) if (p[i]) return i;
        return 0;
    endfunction : pick
    function automatic logic [17:0] hd(input ces_bus_s x);
        return {x.valid, x.write, x.addr};
    endfunction : hd
    // One cycle of source, drop and command requests to the far end.
    task poke(input logic [7:0] up, input logic [7:0] dn, input logic [2:0] c);
        @(posedge sys_clk);
        {raise, drop, send} <= {up, dn, c};
        @(posedge sys_clk);
        {raise, drop, send} <= 19'h00000;
    endtask : poke
    // Boundary pulse with opcode flags trap, wait, stop, halt.
    task step(input logic [3:0] op);
        @(posedge sys_clk);
        {insn_boundary, soft_trap_opcode, wait_opcode, stop_opcode, debug_halt_opcode} <= {1'b1, op};
        @(posedge sys_clk);
        {insn_boundary, soft_trap_opcode, wait_opcode, stop_opcode, debug_halt_opcode} <= 5'h00;
    endtask : step
    task await(input int w, input logic v);
        repeat (30) begin
            @(posedge sys_clk);
            #1;
            if ((w ? core_clk_en : in_background) === v) return;
        end
    endtask : await
    // Full entry walk checked cycle by cycle.
    task entry(input logic trap, input logic [15:0] va);
        ces_bus_s b [1:11];
        logic [7:0] r [1:11];
        logic [39:0] v;
        logic [15:0] sp, vec;
        @(posedge sys_clk);
        ctx <= 40'({$random(seed), $random(seed)});
        stack_ptr <= 16'($random(seed));
        step({trap, 3'h0});
        v = {ctx.ret_ptr[7:0], ctx.ret_ptr[15:8], ctx.index_low, ctx.accum, ctx.cond_code_reg};
        sp = stack_ptr;
        for (int k = 1; k <= 11; k++) begin
            @(posedge sys_clk);
            #1;
            b[k] = bus;
            r[k] = bus_rdata;
        end
        for (int k = 1; k <= 5; k++) `CHK("push", {2'b11, sp - 16'(k - 1), v[47-8*k -: 8]}, b[k])
        `CHK("vec_hi", {2'b10, va}, hd(b[6]))
        `CHK("vec_lo", {2'b10, va + 16'h0001}, hd(b[7]))
        `CHK("idle", 1'b0, b[8].valid)
        vec = {r[6], r[7]};
        for (int k = 9; k <= 11; k++) `CHK("fill", {2'b10, vec + 16'(k - 9)}, hd(b[k]))
        `CHK("load", {1'b1, vec}, {pc_load, new_pc})
        `CHK("mask", 1'b1, global_mask)
    endtask : entry

    initial begin
        tick(20);
        srst <= 1'b0;
        tick(3);
        entry(1'b1, TRAP_VEC);
        pend = 8'($random(seed)) | 8'h80;
        poke(pend, 8'h00, 3'h0);
        tick(2);
        step(4'h0);
        tick(4);
        #1;
        `CHK("masked", 1'b0, bus.valid | busy)
        while (pend != 8'h00) begin
            sel = pick(pend);
            @(posedge sys_clk);
            mask_clear_req <= 1'b1;
            @(posedge sys_clk);
            mask_clear_req <= 1'b0;
            tick(1);
            #1;
            `CHK("unmask", 1'b0, global_mask)
            entry(1'b0, VEC_TOP - 16'(2 * (sel + 2)));
            poke(8'h00, 8'h01 << sel, 3'h0);
            pend[sel] = 1'b0;
            tick(3);
        end
        step(4'h4);
        tick(1);
        #1;
        `CHK("wait", 2'b00, {global_mask, core_clk_en})
        poke(8'h20, 8'h00, 3'h0);
        await(1, 1'b1);
        `CHK("wake", 1'b1, core_clk_en)
        entry(1'b0, VEC_TOP - 16'h000E);
        poke(8'h00, 8'h20, 3'h0);
        step(4'h4);
        poke(8'h00, 8'h00, CES_CMD_HALT);
        await(0, 1'b1);
        `CHK("wait_dbg", 2'b11, {in_background, core_clk_en})
        for (int i = 0; i < 3; i++) begin
            poke(8'h00, 8'h00, exits[i]);
            await(0, 1'b0);
            `CHK("dbg_exit", 1'b0, in_background)
            step(4'h1);
            await(0, 1'b1);
            `CHK("halt_op", 1'b1, in_background)
            poke(8'h00, 8'h00, CES_CMD_HALT);
            tick(8);
            #1;
            `CHK("dbg_hold", 1'b1, in_background)
        end
        poke(8'h00, 8'h00, CES_CMD_RESUME);
        await(0, 1'b0);
        {debug_enable_bit, debug_wire_pin, stop_clk_keep} <= 3'b111;
        tick(4);
        step(4'h2);
        tick(2);
        #1;
        `CHK("stop_keep", 2'b11, {osc_keep, periodic_keep})
        poke(8'h00, 8'h00, CES_CMD_HALT);
        await(0, 1'b1);
        `CHK("stop_dbg", 2'b11, {in_background, core_clk_en})
        stop_test();
    end

    initial begin
        tick(5000);
        fail_count++;
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
